// ### rtl/buffer_pool_manager_consts.svh
// Register numbers, field positions, reset values and figures of the buffer pool manager registers
`ifndef BUFFER_POOL_MANAGER_CONSTS_SVH
`define BUFFER_POOL_MANAGER_CONSTS_SVH

`define BPM_REG_BUFFER_CONFIG     16'h1c00
`define BPM_REG_DROP_LIMIT        16'h1c01
`define BPM_REG_PAUSE_LEVEL       16'h1c02
`define BPM_REG_RESUME_LEVEL      16'h1c03
`define BPM_REG_FLOOD_LIMIT       16'h1c04
`define BPM_REG_PORT0_DROPS       16'h1c05

`define BPM_CFG_COUNTER_TEST_BIT  6
`define BPM_CFG_FIXED_PRIO_BIT    5
`define BPM_CFG_PACING_MSB        4
`define BPM_CFG_PACING_LSB        2
`define BPM_CFG_YELLOW_BIT        1
`define BPM_CFG_RED_BIT           0
`define BPM_CFG_WRITE_MASK        32'h0000007f

`define BPM_CFG_RESET             32'h00000000
`define BPM_DROP_LOW_RESET        8'h49
`define BPM_DROP_HIGH_RESET       8'h64
`define BPM_PAUSE_LOW_RESET       8'h21
`define BPM_PAUSE_HIGH_RESET      8'h3c
`define BPM_RESUME_LOW_RESET      8'h03
`define BPM_RESUME_HIGH_RESET     8'h07
`define BPM_FLOOD_RESET           8'h31

`define BPM_COUNT_RESET           32'h00000000
`define BPM_COUNT_MAX             32'hffffffff
`define BPM_COUNT_TEST_PATTERN    32'h07fffffc

`define BPM_ACTIVE_BUFFERS        8'h24
`define BPM_BUFFER_BYTES          128

`endif

// ### rtl/buffer_pool_manager_pkg.sv
// Types shared by the buffer pool manager register files
package buffer_pool_manager_pkg;

	typedef enum logic [1:0] {
		LEVEL_QUIET,
		LEVEL_HIGH,
		LEVEL_LOW
	} level_select_type;

	typedef enum logic {
		SERVICE_ROUND_ROBIN,
		SERVICE_FIXED_PRIORITY
	} service_order_type;

endpackage

// ### rtl/port_level_monitor.sv
// Per-port buffer usage compare against the selected thresholds
`include "buffer_pool_manager_consts.svh"

module port_level_monitor (
	input  wire logic                                       mclk_i,
	input  wire logic                                       arst_n_i,
	input  wire logic [7:0]                                 buffers_used_i,
	input  wire buffer_pool_manager_pkg::level_select_type  level_sel_i,
	input  wire logic [7:0]                                 drop_low_i,
	input  wire logic [7:0]                                 drop_high_i,
	input  wire logic [7:0]                                 pause_low_i,
	input  wire logic [7:0]                                 pause_high_i,
	input  wire logic [7:0]                                 resume_low_i,
	input  wire logic [7:0]                                 resume_high_i,
	output logic                                            over_limit_o,
	output logic                                            pause_o,
	output logic                                            resume_o
);

	logic [7:0] drop_sel;
	logic [7:0] pause_sel;
	logic [7:0] resume_sel;
	logic       over_limit_next;
	logic       pause_next;
	logic       resume_next;

	// ---------------------------------------------------------------
	// Threshold select and compare
	// ---------------------------------------------------------------
	always_comb begin
		drop_sel   = (level_sel_i == buffer_pool_manager_pkg::LEVEL_LOW) ? drop_low_i : drop_high_i;
		pause_sel  = (level_sel_i == buffer_pool_manager_pkg::LEVEL_LOW) ? pause_low_i : pause_high_i;
		resume_sel = (level_sel_i == buffer_pool_manager_pkg::LEVEL_LOW) ? resume_low_i : resume_high_i;
		over_limit_next = (buffers_used_i >= drop_sel);
		pause_next      = (buffers_used_i >= pause_sel);
		resume_next     = (buffers_used_i <= resume_sel);
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			over_limit_o <= 1'b0;
			pause_o      <= 1'b0;
			resume_o     <= 1'b0;
		end else begin
			over_limit_o <= over_limit_next;
			pause_o      <= pause_next;
			resume_o     <= resume_next;
		end
	end

endmodule // port_level_monitor

// ### rtl/buffer_pool_manager_csrs.sv
// Buffer pool manager control and status registers with port 0 drop counter
`include "buffer_pool_manager_consts.svh"

module buffer_pool_manager_csrs (
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [15:0]  reg_addr_i,
	input  wire logic [31:0]  reg_wdata_i,
	input  wire logic [23:0]  buffers_used_i,
	input  wire logic         port0_space_drop_i,
	input  wire logic         port0_red_i,
	input  wire logic         port0_yellow_i,
	input  wire logic         port0_random_hit_i,
	output logic [31:0]       reg_rdata_o,
	output logic              fixed_priority_o,
	output logic [2:0]        pacing_enable_o,
	output logic              yellow_random_o,
	output logic              red_discard_o,
	output logic [7:0]        flood_limit_o,
	output logic [2:0]        port_active_o,
	output logic [2:0]        port_over_limit_o,
	output logic [2:0]        port_pause_o,
	output logic [2:0]        port_resume_o,
	output logic              port0_dropped_o
);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function automatic logic [2:0] reg_index(input logic [15:0] addr);
		if (addr == `BPM_REG_BUFFER_CONFIG) begin
			reg_index = 3'h0;
		end else if (addr == `BPM_REG_DROP_LIMIT) begin
			reg_index = 3'h1;
		end else if (addr == `BPM_REG_PAUSE_LEVEL) begin
			reg_index = 3'h2;
		end else if (addr == `BPM_REG_RESUME_LEVEL) begin
			reg_index = 3'h3;
		end else if (addr == `BPM_REG_FLOOD_LIMIT) begin
			reg_index = 3'h4;
		end else if (addr == `BPM_REG_PORT0_DROPS) begin
			reg_index = 3'h5;
		end else begin
			reg_index = 3'h7;
		end
	endfunction

	logic [6:0]  config_reg;
	logic [6:0]  config_next;
	logic [15:0] drop_reg;
	logic [15:0] drop_next;
	logic [15:0] pause_reg;
	logic [15:0] pause_next;
	logic [15:0] resume_reg;
	logic [15:0] resume_next;
	logic [7:0]  flood_reg;
	logic [7:0]  flood_next;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] rdata_next;
	logic        dropped_next;
	logic [2:0]  wr_idx;
	logic [2:0]  rd_idx;
	logic [2:0]  active_next;
	logic [1:0]  active_count;
	buffer_pool_manager_pkg::level_select_type level_sel;

	assign wr_idx = reg_index(reg_addr_i);
	assign rd_idx = reg_index(reg_addr_i);

	// ---------------------------------------------------------------
	// Writable registers
	// ---------------------------------------------------------------
	always_comb begin
		config_next = config_reg;
		drop_next   = drop_reg;
		pause_next  = pause_reg;
		resume_next = resume_reg;
		flood_next  = flood_reg;
		if (reg_wr_i) begin
			if (wr_idx == 3'h0) begin
				config_next = reg_wdata_i[6:0];
			end else if (wr_idx == 3'h1) begin
				drop_next = reg_wdata_i[15:0];
			end else if (wr_idx == 3'h2) begin
				pause_next = reg_wdata_i[15:0];
			end else if (wr_idx == 3'h3) begin
				resume_next = reg_wdata_i[15:0];
			end else if (wr_idx == 3'h4) begin
				flood_next = reg_wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			config_reg <= 7'h00;
			drop_reg   <= {`BPM_DROP_LOW_RESET, `BPM_DROP_HIGH_RESET};
			pause_reg  <= {`BPM_PAUSE_LOW_RESET, `BPM_PAUSE_HIGH_RESET};
			resume_reg <= {`BPM_RESUME_LOW_RESET, `BPM_RESUME_HIGH_RESET};
			flood_reg  <= `BPM_FLOOD_RESET;
		end else begin
			config_reg <= config_next;
			drop_reg   <= drop_next;
			pause_reg  <= pause_next;
			resume_reg <= resume_next;
			flood_reg  <= flood_next;
		end
	end

	// ---------------------------------------------------------------
	// Active ports and threshold set
	// ---------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_active
			assign active_next[gp] = (buffers_used_i[gp*8 +: 8] >= `BPM_ACTIVE_BUFFERS);
		end
	endgenerate

	always_comb begin
		active_count = 2'(active_next[0]) + 2'(active_next[1]) + 2'(active_next[2]);
		if (active_count >= 2'd2) begin
			level_sel = buffer_pool_manager_pkg::LEVEL_LOW;
		end else if (active_count == 2'd1) begin
			level_sel = buffer_pool_manager_pkg::LEVEL_HIGH;
		end else begin
			level_sel = buffer_pool_manager_pkg::LEVEL_QUIET;
		end
	end

	generate
		for (gp = 0; gp < 3; gp++) begin : g_monitor
			port_level_monitor port_level_monitor_i (
				.mclk_i        (mclk_i),
				.arst_n_i      (arst_n_i),
				.buffers_used_i(buffers_used_i[gp*8 +: 8]),
				.level_sel_i   (level_sel),
				.drop_low_i    (drop_reg[15:8]),
				.drop_high_i   (drop_reg[7:0]),
				.pause_low_i   (pause_reg[15:8]),
				.pause_high_i  (pause_reg[7:0]),
				.resume_low_i  (resume_reg[15:8]),
				.resume_high_i (resume_reg[7:0]),
				.over_limit_o  (port_over_limit_o[gp]),
				.pause_o       (port_pause_o[gp]),
				.resume_o      (port_resume_o[gp])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Port 0 drop counter
	// ---------------------------------------------------------------
	always_comb begin
		dropped_next = port0_space_drop_i
			| (port0_red_i & config_reg[`BPM_CFG_RED_BIT])
			| (port0_yellow_i & config_reg[`BPM_CFG_YELLOW_BIT] & port0_random_hit_i);
		count_next = count_reg;
		// A drop in the read cycle lands after the clear so it is not lost
		if (reg_rd_i && rd_idx == 3'h5) begin
			if (config_reg[`BPM_CFG_COUNTER_TEST_BIT]) begin
				count_next = `BPM_COUNT_TEST_PATTERN;
			end else begin
				count_next = `BPM_COUNT_RESET;
			end
			if (dropped_next) begin
				count_next = count_next + 32'h1;
			end
		end else if (dropped_next && count_reg != `BPM_COUNT_MAX) begin
			count_next = count_reg + 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h0;
		if (reg_rd_i) begin
			if (rd_idx == 3'h0) begin
				rdata_next = {25'h0, config_reg};
			end else if (rd_idx == 3'h1) begin
				rdata_next = {16'h0, drop_reg};
			end else if (rd_idx == 3'h2) begin
				rdata_next = {16'h0, pause_reg};
			end else if (rd_idx == 3'h3) begin
				rdata_next = {16'h0, resume_reg};
			end else if (rd_idx == 3'h4) begin
				rdata_next = {24'h0, flood_reg};
			end else if (rd_idx == 3'h5) begin
				rdata_next = count_reg;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_reg         <= `BPM_COUNT_RESET;
			reg_rdata_o       <= 32'h0;
			fixed_priority_o  <= 1'b0;
			pacing_enable_o   <= 3'h0;
			yellow_random_o   <= 1'b0;
			red_discard_o     <= 1'b0;
			flood_limit_o     <= `BPM_FLOOD_RESET;
			port_active_o     <= 3'h0;
			port0_dropped_o   <= 1'b0;
		end else begin
			count_reg         <= count_next;
			reg_rdata_o       <= rdata_next;
			fixed_priority_o  <= config_next[`BPM_CFG_FIXED_PRIO_BIT];
			pacing_enable_o   <= config_next[`BPM_CFG_PACING_MSB:`BPM_CFG_PACING_LSB];
			yellow_random_o   <= config_next[`BPM_CFG_YELLOW_BIT];
			red_discard_o     <= config_next[`BPM_CFG_RED_BIT];
			flood_limit_o     <= flood_next;
			port_active_o     <= active_next;
			port0_dropped_o   <= dropped_next;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_count_read;
		reg_rd_i && reg_addr_i == `BPM_REG_PORT0_DROPS;
	endsequence

	property p_test_load;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_count_read and config_reg[6] && !dropped_next |=> count_reg == `BPM_COUNT_TEST_PATTERN;
	endproperty
	a_test_load: assert property (p_test_load) else $error("test pattern not loaded");

	property p_service;
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_wr_i && reg_addr_i == `BPM_REG_BUFFER_CONFIG |=> fixed_priority_o == $past(reg_wdata_i[5]);
	endproperty
	a_service: assert property (p_service) else $error("service order wrong");

	property p_pacing;
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_wr_i && reg_addr_i == `BPM_REG_BUFFER_CONFIG |=> pacing_enable_o == $past(reg_wdata_i[4:2]);
	endproperty
	a_pacing: assert property (p_pacing) else $error("pacing enables wrong");

	property p_active;
		@(posedge mclk_i) disable iff (!arst_n_i)
		buffers_used_i[7:0] == 8'h24 |=> port_active_o[0];
	endproperty
	a_active: assert property (p_active) else $error("port 0 not active");

	property p_clear;
		@(posedge mclk_i) disable iff (!arst_n_i)
		s_count_read and !config_reg[6] && !dropped_next |=> count_reg == 32'h0 && reg_rdata_o == $past(count_reg);
	endproperty
	a_clear: assert property (p_clear) else $error("clear on read failed");

	property p_saturate;
		@(posedge mclk_i) disable iff (!arst_n_i)
		count_reg == `BPM_COUNT_MAX && !(reg_rd_i && reg_addr_i == `BPM_REG_PORT0_DROPS) |=> count_reg == `BPM_COUNT_MAX;
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter wrapped");

	property p_count;
		@(posedge mclk_i) disable iff (!arst_n_i)
		port0_space_drop_i && count_reg != `BPM_COUNT_MAX && !(reg_rd_i && reg_addr_i == `BPM_REG_PORT0_DROPS)
		|=> count_reg == $past(count_reg) + 32'h1;
	endproperty
	a_count: assert property (p_count) else $error("drop not counted");

	property p_red;
		@(posedge mclk_i) disable iff (!arst_n_i)
		port0_red_i && config_reg[0] |=> port0_dropped_o;
	endproperty
	a_red: assert property (p_red) else $error("red packet not dropped");

	property p_reserved;
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_rd_i && reg_addr_i == `BPM_REG_FLOOD_LIMIT |=> reg_rdata_o[31:8] == 24'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule // buffer_pool_manager_csrs

// ### sim/switch_buffer_manager_csrs_bench.sv
// Self-checking bench for the buffer pool manager registers
`include "buffer_pool_manager_consts.svh"

module switch_buffer_manager_csrs_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic         mclk_i             = 1'b0;
	logic         arst_n_i           = 1'b0;
	logic         reg_wr_i           = 1'b0;
	logic         reg_rd_i           = 1'b0;
	logic [15:0]  reg_addr_i         = 16'h0000;
	logic [31:0]  reg_wdata_i        = 32'h00000000;
	logic [23:0]  buffers_used_i     = 24'h000000;
	logic         port0_space_drop_i = 1'b0;
	logic         port0_red_i        = 1'b0;
	logic         port0_yellow_i     = 1'b0;
	logic         port0_random_hit_i = 1'b0;
	logic [31:0]  reg_rdata_o;
	logic         fixed_priority_o;
	logic [2:0]   pacing_enable_o;
	logic         yellow_random_o;
	logic         red_discard_o;
	logic [7:0]   flood_limit_o;
	logic [2:0]   port_active_o;
	logic [2:0]   port_over_limit_o;
	logic [2:0]   port_pause_o;
	logic [2:0]   port_resume_o;
	logic         port0_dropped_o;
	int           mismatches = 0;
	int           n_compared = 0;
	int           cycles     = 0;
	logic         rd_q       = 1'b0;
	logic [31:0]  exp_q[$];
	logic [31:0]  cnt;
	logic [31:0]  shadow [0:4];
	logic [31:0]  mask [0:4] = '{`BPM_CFG_WRITE_MASK, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h000000ff};

	buffer_pool_manager_csrs buffer_pool_manager_csrs_i (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .buffers_used_i(buffers_used_i),
		.port0_space_drop_i(port0_space_drop_i), .port0_red_i(port0_red_i), .port0_yellow_i(port0_yellow_i),
		.port0_random_hit_i(port0_random_hit_i), .reg_rdata_o(reg_rdata_o), .fixed_priority_o(fixed_priority_o),
		.pacing_enable_o(pacing_enable_o), .yellow_random_o(yellow_random_o), .red_discard_o(red_discard_o),
		.flood_limit_o(flood_limit_o), .port_active_o(port_active_o), .port_over_limit_o(port_over_limit_o),
		.port_pause_o(port_pause_o), .port_resume_o(port_resume_o), .port0_dropped_o(port0_dropped_o)
	);

	always #5 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict();
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge mclk_i) begin
		rd_q <= reg_rd_i;
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("MISMATCH t=%0t timeout", $time);
			print_verdict();
		end
	end

	// Read data lasts one cycle, so it is taken at the falling edge after the read
	always @(negedge mclk_i) begin
		if (rd_q) begin
			if (exp_q.size() > 0)
				check(reg_rdata_o, exp_q.pop_front());
			else begin
				mismatches++;
				$display("MISMATCH t=%0t unexpected read data", $time);
			end
		end else
			check(reg_rdata_o, 32'h00000000);
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
		if (a >= `BPM_REG_BUFFER_CONFIG && a <= `BPM_REG_FLOOD_LIMIT)
			shadow[a[2:0]] = d & mask[a[2:0]];
		if (a == `BPM_REG_BUFFER_CONFIG) begin
			check(32'(fixed_priority_o), 32'(shadow[0][5]));
			check(32'(pacing_enable_o), 32'(shadow[0][4:2]));
			check(32'(yellow_random_o), 32'(shadow[0][1]));
			check(32'(red_discard_o), 32'(shadow[0][0]));
		end
		check(32'(flood_limit_o), shadow[4]);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic drop);
		@(negedge mclk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		port0_space_drop_i = drop;
		exp_q.push_back(exp);
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		port0_space_drop_i = 1'b0;
	endtask

	// A clearing read reloads zero, or the test pattern when the test bit is set
	task automatic rd_cnt(input logic drop);
		rd(`BPM_REG_PORT0_DROPS, cnt, drop);
		cnt = (shadow[0][`BPM_CFG_COUNTER_TEST_BIT] ? `BPM_COUNT_TEST_PATTERN : `BPM_COUNT_RESET) + 32'(drop);
	endtask

	task automatic drops(input int n);
		logic [3:0] r;
		logic       hit;
		hit = 1'b0;
		for (int k = 0; k < n; k++) begin
			@(negedge mclk_i);
			check(32'(port0_dropped_o), 32'(hit));
			r = 4'($urandom);
			{port0_space_drop_i, port0_red_i, port0_yellow_i, port0_random_hit_i} = r;
			hit = r[3] || (r[2] && shadow[0][0]) || (r[1] && r[0] && shadow[0][1]);
			if (hit)
				cnt = cnt + 1;
		end
		@(negedge mclk_i);
		check(32'(port0_dropped_o), 32'(hit));
		{port0_space_drop_i, port0_red_i, port0_yellow_i, port0_random_hit_i} = 4'h0;
	endtask

	task automatic levels();
		logic [7:0] u;
		logic [1:0] n;
		logic       low;
		logic [2:0] ea, eo, ep, er;
		n = 2'd0;
		for (int p = 0; p < 3; p++) begin
			ea[p] = buffers_used_i[8*p+:8] >= `BPM_ACTIVE_BUFFERS;
			n = n + 2'(ea[p]);
		end
		low = n >= 2'd2;
		for (int p = 0; p < 3; p++) begin
			u = buffers_used_i[8*p+:8];
			eo[p] = u >= (low ? shadow[1][15:8] : shadow[1][7:0]);
			ep[p] = u >= (low ? shadow[2][15:8] : shadow[2][7:0]);
			er[p] = u <= (low ? shadow[3][15:8] : shadow[3][7:0]);
		end
		check(32'(port_active_o), 32'(ea));
		check(32'(port_over_limit_o), 32'(eo));
		check(32'(port_pause_o), 32'(ep));
		check(32'(port_resume_o), 32'(er));
	endtask

	// Usage is steered to just below, at and above each threshold
	task automatic run_levels();
		int base [0:6];
		base = '{36, shadow[1][15:8], shadow[1][7:0], shadow[2][15:8], shadow[2][7:0],
			shadow[3][15:8], shadow[3][7:0]};
		for (int i = 0; i < 40; i++) begin
			@(negedge mclk_i);
			for (int p = 0; p < 3; p++)
				buffers_used_i[8*p+:8] = 8'(base[$urandom_range(0, 6)] + $urandom_range(0, 2) - 1);
			repeat (3) @(negedge mclk_i);
			levels();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h8b18));
		cnt = `BPM_COUNT_RESET;
		shadow = '{`BPM_CFG_RESET, {16'h0000, `BPM_DROP_LOW_RESET, `BPM_DROP_HIGH_RESET},
			{16'h0000, `BPM_PAUSE_LOW_RESET, `BPM_PAUSE_HIGH_RESET},
			{16'h0000, `BPM_RESUME_LOW_RESET, `BPM_RESUME_HIGH_RESET}, {24'h000000, `BPM_FLOOD_RESET}};
		repeat (8) @(negedge mclk_i);
		arst_n_i = 1'b1;
		check(32'(flood_limit_o), 32'h00000031);
		for (int a = 0; a < 6; a++)
			rd(16'h1c00 + 16'(a), (a < 5) ? shadow[a] : cnt, 1'b0);
		rd(16'h1c06, 32'h00000000, 1'b0);
		run_levels();
		for (int i = 0; i < 16; i++)
			wr((i % 7 == 5) ? 16'h1c06 : 16'h1c00 + 16'(i % 7 == 6 ? 0 : i % 7), $urandom);
		for (int a = 0; a < 5; a++)
			rd(16'h1c00 + 16'(a), shadow[a], 1'b0);
		run_levels();
		for (int m = 0; m < 4; m++) begin
			wr(`BPM_REG_BUFFER_CONFIG, 32'(m));
			drops(20);
			rd_cnt(1'b0);
		end
		rd_cnt(1'b0);
		wr(`BPM_REG_BUFFER_CONFIG, 32'h00000043);
		drops(10);
		rd_cnt(1'b0);
		drops(5);
		rd_cnt(1'b1);
		rd_cnt(1'b0);
		wr(`BPM_REG_BUFFER_CONFIG, 32'h00000000);
		rd_cnt(1'b1);
		rd_cnt(1'b0);
		repeat (3) @(negedge mclk_i);
		print_verdict();
	end

endmodule // switch_buffer_manager_csrs_bench
